// file: quad_byte_average_pack_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// RL1: both operations are 32-bit encodings
// RL2: low variants fill bits 23..16, 7..0
// RL3: high variants fill bits 31..24, 15..8
// RL4: mean is four-byte sum shifted right two
// RL5: round up on remainder of two or more, truncate discards
// RL6: global rounding bit ignored
// RL7: average sources only pairs R1:0 and R3:2
// RL8: one index aligns both sources
// RL9: index low bits pick four bytes
// RL10: reverse option swaps pair registers
// RL11: no misalignment exception for parallel loads issued with these ops
// RL12: pack takes bytes 0,2 of each source
// RL13: may issue with permitted 16-bit instructions
// RL14: rounding adds two before shift
// RL15: no status flags modified
module quad_byte_average_pack_unit (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic issue,
	input wire qbap_pkg::op_e op,
	input wire logic instr_is_32bit,
	input wire logic round_sel,
	input wire logic high_byte_sel,
	input wire logic reverse_sel,
	input wire logic global_rounding_mode_bit,
	input wire logic [31:0] first_alignment_index,
	input wire logic [2:0] src0_pair_low,
	input wire logic [2:0] src1_pair_low,
	input wire logic [31:0] src0_lo,
	input wire logic [31:0] src0_hi,
	input wire logic [31:0] src1_lo,
	input wire logic [31:0] src1_hi,
	input wire logic [2:0] dest_idx,
	input wire logic parallel_load,
	input wire logic [1:0] parallel_load_addr_lsb,
	input wire logic parallel_slot_16bit_ok,
	output logic [31:0] result_reg,
	output logic [2:0] dest_reg_idx_reg,
	output logic result_valid_reg,
	output logic illegal_op_reg,
	output logic misalign_exc_reg,
	output logic flags_write_reg
);
	import qbap_pkg::*;
	// ==================== operand alignment
	logic [63:0] pair0;
	logic [63:0] pair1;
	logic [1:0] align;
	logic [31:0] y;
	logic [31:0] z;
	logic [7:0] mean_upper;
	logic [7:0] mean_lower;
	logic [31:0] avg_word;
	logic [31:0] pack_word;
	logic legal;
	logic [31:0] result_next;
	always_comb begin
		// reverse swaps which register feeds the low bytes
		pair0 = reverse_sel ? {src0_lo, src0_hi} : {src0_hi, src0_lo}; // RL10
		pair1 = reverse_sel ? {src1_lo, src1_hi} : {src1_hi, src1_lo}; // RL10
		align = first_alignment_index[1:0]; // RL8
		y = 32'h0000_0000;
		z = 32'h0000_0000;
		case (align) // RL9
			2'h0: begin
				y = pair0[31:0];
				z = pair1[31:0];
			end
			2'h1: begin
				y = pair0[39:8];
				z = pair1[39:8];
			end
			2'h2: begin
				y = pair0[47:16];
				z = pair1[47:16];
			end
			2'h3: begin
				y = pair0[55:24];
				z = pair1[55:24];
			end
			default: begin
				y = pair0[31:0];
				z = pair1[31:0];
			end
		endcase
	end
	// ==================== means
	// global_rounding_mode_bit deliberately not used
	byte_mean4 u_mean_upper ( // RL6
		.a0(y[31:24]),
		.a1(y[23:16]),
		.b0(z[31:24]),
		.b1(z[23:16]),
		.round_up(round_sel),
		.mean(mean_upper)
	);
	byte_mean4 u_mean_lower (
		.a0(y[15:8]),
		.a1(y[7:0]),
		.b0(z[15:8]),
		.b1(z[7:0]),
		.round_up(round_sel),
		.mean(mean_lower)
	);
	// ==================== result assembly
	always_comb begin
		avg_word = 32'h0000_0000;
		if (high_byte_sel) begin
			avg_word[31:24] = mean_upper; // RL3
			avg_word[15:8] = mean_lower; // RL3
		end else begin
			avg_word[23:16] = mean_upper; // RL2
			avg_word[7:0] = mean_lower; // RL2
		end
		pack_word = {src1_lo[23:16], src1_lo[7:0],
			src0_lo[23:16], src0_lo[7:0]}; // RL12
		legal = instr_is_32bit; // RL1
		if (op == op_average) begin
			legal = instr_is_32bit
				&& (src0_pair_low == pair_a_low || src0_pair_low == pair_b_low)
				&& (src1_pair_low == pair_a_low || src1_pair_low == pair_b_low); // RL7
		end
		result_next = (op == op_pack) ? pack_word : avg_word;
	end
	// ==================== result write
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			result_reg <= result_rst;
			dest_reg_idx_reg <= dest_rst;
			result_valid_reg <= 1'b0;
		end else begin
			result_valid_reg <= issue && op != op_none && legal;
			if (issue && op != op_none && legal) begin
				result_reg <= result_next;
				dest_reg_idx_reg <= dest_idx;
			end
		end
	end
	// ==================== illegal encodings
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			illegal_op_reg <= 1'b0;
		end else begin
			// a bad pair, short encoding or bad 16-bit partner
			illegal_op_reg <= issue && op != op_none
				&& (!legal || (parallel_load && !parallel_slot_16bit_ok)); // RL13
		end
	end
	// ==================== parallel load exceptions
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			misalign_exc_reg <= 1'b0;
		end else begin
			// misaligned loads beside these ops are tolerated
			misalign_exc_reg <= parallel_load
				&& parallel_load_addr_lsb != 2'h0
				&& !(issue && op != op_none); // RL11
		end
	end
	// ==================== status flags
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flags_write_reg <= 1'b0;
		end else begin
			flags_write_reg <= 1'b0; // RL15
		end
	end
endmodule // quad_byte_average_pack_unit

// file: qbap_pkg.sv
package qbap_pkg;
	// ==================== operation encoding
	typedef enum logic [2:0] {
		op_none = 3'b001,
		op_average = 3'b010,
		op_pack = 3'b100
	} op_e;
	// ==================== widths and field positions
	localparam int word_w = 32;
	localparam int byte_w = 8;
	localparam int align_w = 2;
	localparam int reg_idx_w = 3;
	localparam int sum_w = 10;
	localparam int avg_shift = 2;
	localparam logic [9:0] round_bias = 10'h002;
	localparam int lo_mean_pos = 0;
	localparam int hi_mean_pos = 8;
	localparam int upper_mean_pos = 16;
	localparam int pack_b0_pos = 0;
	localparam int pack_b1_pos = 16;
	// ==================== valid source pairs
	localparam logic [2:0] pair_a_low = 3'h0;
	localparam logic [2:0] pair_b_low = 3'h2;
	// ==================== reset values
	localparam logic [31:0] result_rst = 32'h0000_0000;
	localparam logic [2:0] dest_rst = 3'h0;
	localparam int instr_len_bits = 32;
endpackage

// file: byte_mean4.sv
`timescale 1ns/1ps
module byte_mean4 (
	input wire logic [7:0] a0,
	input wire logic [7:0] a1,
	input wire logic [7:0] b0,
	input wire logic [7:0] b1,
	input wire logic round_up,
	output logic [7:0] mean
);
	import qbap_pkg::*;
	logic [9:0] sum;
	logic [9:0] biased;
	always_comb begin
		sum = {2'b00, a0} + {2'b00, a1} + {2'b00, b0} + {2'b00, b1}; // RL4
		biased = round_up ? sum + round_bias : sum; // RL5 RL14
		mean = biased[9:2]; // RL4
	end
endmodule // byte_mean4

// file: qbap_regfile.sv
`timescale 1ns/1ps
// ==========
// pair read ports of the data registers
module qbap_regfile (
	input wire logic [5:0][31:0] rf,
	input wire logic [2:0] s0,
	input wire logic [2:0] s1,
	output logic [31:0] s0_lo,
	output logic [31:0] s0_hi,
	output logic [31:0] s1_lo,
	output logic [31:0] s1_hi
);
	assign s0_lo = rf[s0];
	assign s0_hi = rf[s0 + 3'h1];
	assign s1_lo = rf[s1];
	assign s1_hi = rf[s1 + 3'h1];
endmodule // qbap_regfile

// file: qbap_checker.sv
`timescale 1ns/1ps
module qbap_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic issue,
	input wire qbap_pkg::op_e op,
	input wire logic instr_is_32bit,
	input wire logic high_byte_sel,
	input wire logic [2:0] src0_pair_low,
	input wire logic [2:0] src1_pair_low,
	input wire logic [31:0] src0_lo,
	input wire logic [31:0] src1_lo,
	input wire logic parallel_load,
	input wire logic parallel_slot_16bit_ok,
	input wire logic [31:0] result_reg,
	input wire logic result_valid_reg,
	input wire logic illegal_op_reg,
	input wire logic misalign_exc_reg,
	input wire logic flags_write_reg
);
	import qbap_pkg::*;
	// ==========
	// checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire t = issue && instr_is_32bit;
	wire p0 = src0_pair_low inside {pair_a_low, pair_b_low};
	wire av = t && op == op_average && p0
		&& src1_pair_low inside {pair_a_low, pair_b_low};
	wire pk = t && op == op_pack;
	chk_short_refused: assert property (
		issue && op != op_none && !instr_is_32bit
		|=> illegal_op_reg && !result_valid_reg) else $error("short op taken");
	chk_pack_valid: assert property (
		pk && parallel_slot_16bit_ok |=> result_valid_reg) else $error("no valid");
	chk_pack_bytes: assert property (
		pk |=> result_reg == {$past(src1_lo[23:16]), $past(src1_lo[7:0]),
		$past(src0_lo[23:16]), $past(src0_lo[7:0])}) else $error("pack bytes");
	chk_low_zero: assert property (
		av && !high_byte_sel |=> !(result_reg & 32'hff00_ff00)) else $error("low");
	chk_high_zero: assert property (
		av && high_byte_sel |=> !(result_reg & 32'h00ff_00ff)) else $error("high");
	chk_bad_pair: assert property (
		t && op == op_average && !p0 |=> illegal_op_reg && !result_valid_reg)
		else $error("bad pair taken");
	chk_no_misalign: assert property (
		t && op != op_none && parallel_load |=> !misalign_exc_reg)
		else $error("misalign raised");
	chk_no_flags: assert property (
		t |=> !flags_write_reg [*2]) else $error("flags written");
	cover property (av && high_byte_sel);
	cover property (pk);
	cover property (illegal_op_reg);
	cover property (av && !high_byte_sel);
endmodule // qbap_checker
bind quad_byte_average_pack_unit qbap_checker chk (.*);

// file: quad_byte_average_pack_unit_bench.sv
`timescale 1ns/1ps
module quad_byte_average_pack_unit_bench;
	import qbap_pkg::*;
	logic ref_clk = 0, sys_rst = 1, issue = 0, instr_is_32bit = 1;
	logic round_sel = 0, high_byte_sel = 0, reverse_sel = 0, parallel_load = 0;
	logic global_rounding_mode_bit = 0, parallel_slot_16bit_ok = 1;
	op_e op = op_none;
	logic [31:0] first_alignment_index = 0, src0_lo, src0_hi, src1_lo, src1_hi;
	logic [31:0] result_reg;
	logic [2:0] src0_pair_low = 0, src1_pair_low = 2, dest_idx = 3'h3;
	logic [2:0] dest_reg_idx_reg;
	logic [1:0] parallel_load_addr_lsb = 0;
	logic result_valid_reg, illegal_op_reg, misalign_exc_reg, flags_write_reg;
	logic [5:0][31:0] rf = {32'hbeef_badd, 32'hfeed_face, 32'hffff_01fd,
		32'hfe7f_0304, 32'h0380_fffe, 32'hffff_0102};
	int bad_count = 0, check_count = 0;
	always #12.5 ref_clk = ~ref_clk;
	quad_byte_average_pack_unit DUT (.*);
	qbap_regfile far (.rf(rf), .s0(src0_pair_low), .s1(src1_pair_low),
		.s0_lo(src0_lo), .s0_hi(src0_hi), .s1_lo(src1_lo), .s1_hi(src1_hi));
	// ==========
	// helpers
	function automatic logic [31:0] want(input logic [4:0] c);
		logic [63:0] p, q;
		logic [31:0] y, z;
		logic [9:0] u, l;
		p = c[2] ? {rf[0], rf[1]} : {rf[1], rf[0]};
		q = c[2] ? {rf[2], rf[3]} : {rf[3], rf[2]};
		y = p >> (8 * c[1:0]);
		z = q >> (8 * c[1:0]);
		u = y[31:24] + y[23:16] + z[31:24] + z[23:16] + (c[4] ? 2 : 0);
		l = y[15:8] + y[7:0] + z[15:8] + z[7:0] + (c[4] ? 2 : 0);
		return c[3] ? {u[9:2], 8'h00, l[9:2], 8'h00}
			: {8'h00, u[9:2], 8'h00, l[9:2]};
	endfunction
	task chk32(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk32({31'h0, g}, {31'h0, e});
	endtask
	task run(input op_e o);
		@(negedge ref_clk);
		op = o;
		issue = 1;
		@(negedge ref_clk);
		issue = 0;
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#100us;
		bad_count++;
		conclude;
	end
	initial begin
		repeat (3) @(negedge ref_clk);
		sys_rst = 0;
		chk32(result_reg, 32'h0);
		for (int i = 0; i < 32; i++) begin
			{round_sel, high_byte_sel, reverse_sel} = i[4:2];
			first_alignment_index = 32'h5a5a_5a50 | 32'(i[1:0]);
			global_rounding_mode_bit = ~i[4];
			parallel_load = 1;
			parallel_load_addr_lsb = i[1:0];
			run(op_average);
			chk32(result_reg, want(i[4:0]));
			chk1(misalign_exc_reg, 0);
			chk1(result_valid_reg, 1);
			chk32({29'h0, dest_reg_idx_reg}, 32'h3);
			chk1(flags_write_reg, 0);
		end
		$display("average rows done");
		src0_pair_low = 4;
		src1_pair_low = 5;
		run(op_pack);
		chk32(result_reg, 32'hefdd_edce);
		run(op_average);
		chk1(illegal_op_reg, 1);
		chk1(result_valid_reg, 0);
		parallel_slot_16bit_ok = 0;
		run(op_pack);
		chk1(illegal_op_reg, 1);
		chk1(result_valid_reg, 1);
		parallel_slot_16bit_ok = 1;
		instr_is_32bit = 0;
		run(op_pack);
		chk1(result_valid_reg, 0);
		chk32(result_reg, 32'hefdd_edce);
		$display("pack and refusals done");
		sys_rst = 1;
		@(negedge ref_clk);
		sys_rst = 0;
		chk32(result_reg, 32'h0);
		$display("reset done");
		conclude;
	end
endmodule // quad_byte_average_pack_unit_bench
